// ### ppsts_consts.vh
// Constants for the pulse-disciplined timestamp clock
//
// Summary of operation
// - Only top 28 fraction bits count
// - Timestamp is one contiguous 64-bit value
// - Input selector picks exactly one source
// - Output pulse from repeat, loop or master; host gives none
// - Defaults pulse-port in, no out; none command deselects
// - Lose sync after 10 seconds over threshold
// - Programmable ns threshold, default 596
// - Count each synced to unsynced transition caused by threshold loss
// - Count and reload when seconds differ from host by over 1
// - Unsynced over 10 s reloads host time
// - Report last-second frequency error in ppb
// - Capture phase error at each accepted pulse
// - Worst frequency and phase, cleared by stats
// - Count every reference pulse from the selected source
// - Reject and count off-interval pulses
// - Count single missed pulses, two-second gap
// - Record longest gap in whole seconds
// - Stats clear on reset and commands
// - Set command loads host time, clears stats
// - Full reset loads time, defaults selectors
// - Latch clock at pulse, flag free running
// - Measure crystal rate, expose target rate
// - Upper word seconds, lower word fraction
`ifndef PPSTS_CONSTS_VH
`define PPSTS_CONSTS_VH

// ***************************************************
// Register byte offsets
// ***************************************************
`define PPSTS_A_CTRL      8'h00
`define PPSTS_A_CMD       8'h04
`define PPSTS_A_THRESH    8'h08
`define PPSTS_A_HOST_SEC  8'h0C
`define PPSTS_A_HOST_FRAC 8'h10
`define PPSTS_A_TS_LO     8'h14
`define PPSTS_A_TS_HI     8'h18
`define PPSTS_A_STATUS    8'h1C
`define PPSTS_A_PHASE     8'h20
`define PPSTS_A_FREQ      8'h24
`define PPSTS_A_WFREQ     8'h28
`define PPSTS_A_WPHASE    8'h2C
`define PPSTS_A_FAILS     8'h30
`define PPSTS_A_RESYNC    8'h34
`define PPSTS_A_TOTAL     8'h38
`define PPSTS_A_BAD       8'h3C
`define PPSTS_A_MISS1     8'h40
`define PPSTS_A_LONGEST   8'h44
`define PPSTS_A_LAST_LO   8'h48
`define PPSTS_A_LAST_HI   8'h4C
`define PPSTS_A_XTAL      8'h50
`define PPSTS_A_SYNTH     8'h54

// ***************************************************
// Selector codes and command bits
// ***************************************************
`define PPSTS_IN_NONE   3'h0
`define PPSTS_IN_PORT   3'h1
`define PPSTS_IN_HOST   3'h2
`define PPSTS_IN_OVER   3'h3
`define PPSTS_IN_AUX    3'h4
`define PPSTS_OUT_NONE  3'h0
`define PPSTS_OUT_REP   3'h1
`define PPSTS_OUT_LOOP  3'h2
`define PPSTS_OUT_HOST  3'h3
`define PPSTS_OUT_OVER  3'h4
`define PPSTS_CMD_CLR   0
`define PPSTS_CMD_SET   1
`define PPSTS_CMD_RST   2
`define PPSTS_CMD_DEF   3
`define PPSTS_CMD_NONE  4

// ***************************************************
// Reset values and timing
// ***************************************************
`define PPSTS_THRESH_RST 32'h0000_0254
`define PPSTS_THR_UNIX   32'h0000_2EE0
`define PPSTS_THR_WIN    32'h0000_C350
`define PPSTS_CLK_HZ     32'h0BEB_C200
`define PPSTS_SYNTH_HZ   32'h1000_0000
`define PPSTS_TOL_NS     32'h000F_4240
`define PPSTS_CLK_NS     32'h0000_0005
`define PPSTS_TOL_CYC    (`PPSTS_TOL_NS / `PPSTS_CLK_NS)
`define PPSTS_LOSS_SECS  8'h0A
`define PPSTS_INC        36'h1_5798_EE23
`define PPSTS_NS_PER_S   64'h0000_0000_3B9A_CA00

`endif

// ### ppsts_clock.v
// Pulse-disciplined 64-bit timestamp clock with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
`include "ppsts_consts.vh"

module ppsts_clock
(
  input  wire        core_clk,         // 200 MHz clock
  input  wire        rst_n,            // Async reset, active low
  input  wire [7:0]  avs_address,      // Byte address
  input  wire        avs_read,         // Read request
  input  wire        avs_write,        // Write request
  input  wire [31:0] avs_writedata,    // Write data
  input  wire [3:0]  avs_byteenable,   // Byte lanes
  output reg  [31:0] avs_readdata,     // Read data
  output reg         avs_waitrequest,  // Stall
  input  wire        pulse_port_input, // Differential port pulse
  input  wire        aux_pulse_in,     // Auxiliary pulse, unused
  output reg         pulse_out,        // Outgoing pulse
  output reg  [63:0] ts_out,           // Live timestamp
  output reg         synced            // Synchronised flag
);

  // ***************************************************
  // Byte-enable merge, used by the threshold and host time registers
  // ***************************************************
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer i;
    begin
      be_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          be_merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  function [31:0] absval;
    input [31:0] v;
    begin
      absval = v[31] ? (~v + 32'h0000_0001) : v;
    end
  endfunction

  // ***************************************************
  // Reference pulse synchroniser
  // ***************************************************
  reg sy1_q;
  reg sy2_q;
  reg sy3_q;

  // First flop feeds only the second
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy1_q <= 1'b0;
      sy2_q <= 1'b0;
      sy3_q <= 1'b0;
    end
    else
    begin
      sy1_q <= pulse_port_input;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  wire port_edge = sy2_q & ~sy3_q;

  // ***************************************************
  // Registers and state
  // ***************************************************
  reg  [2:0]  in_sel_q;
  reg  [2:0]  out_sel_q;
  reg  [31:0] thresh_q;
  reg  [31:0] host_sec_q;
  reg  [31:0] host_frac_q;
  reg  [63:0] ts_q;
  reg  [31:0] sub_q;
  reg  [15:0] trim_q;
  reg  [31:0] ts_hi_snap_q;
  reg  [31:0] phase_q;
  reg  [31:0] freq_q;
  reg  [31:0] wfreq_q;
  reg  [31:0] wphase_q;
  reg  [31:0] fails_q;
  reg  [31:0] resync_q;
  reg  [31:0] total_q;
  reg  [31:0] bad_q;
  reg  [31:0] miss1_q;
  reg  [31:0] longest_q;
  reg  [63:0] last_q;
  reg         ever_q;
  reg  [31:0] xtal_q;
  reg  [31:0] rem_q;
  reg  [31:0] gap_q;
  reg         have_prev_q;
  reg  [7:0]  over_q;
  reg  [7:0]  unsync_q;
  reg         sec_tick_q;

  wire acc = avs_waitrequest == 1'b0 && (avs_read || avs_write);
  wire wr  = acc && avs_write;
  wire [31:0] cmd = avs_writedata;
  wire cmd_wr = wr && avs_address == `PPSTS_A_CMD;

  // Commands; software set and auto reload share one path
  wire auto_reload = unsync_q > `PPSTS_LOSS_SECS && ~synced;
  wire do_set  = (cmd_wr && (cmd[`PPSTS_CMD_SET] || cmd[`PPSTS_CMD_RST]))
                 || auto_reload;
  wire do_rst  = cmd_wr && cmd[`PPSTS_CMD_RST];
  wire clr_st  = do_set || (cmd_wr && cmd[`PPSTS_CMD_CLR]);

  // ***************************************************
  // Reference pulse selection
  // ***************************************************
  wire sec_wrap;
  reg  ref_edge;

  // Host and auxiliary choices carry no pulse
  always @*
  begin
    case (in_sel_q)
      `PPSTS_IN_PORT: ref_edge = port_edge;
      `PPSTS_IN_OVER: ref_edge = sec_tick_q;
      default:        ref_edge = 1'b0;
    endcase
  end

  // ***************************************************
  // Gap classification against the crystal second
  // ***************************************************
  localparam [31:0] HALF = `PPSTS_CLK_HZ >> 1;
  localparam [31:0] TOL  = `PPSTS_TOL_CYC;
  wire [31:0] rsec = gap_q + ((rem_q >= HALF) ? 32'h0000_0001 : 32'h0);
  wire [31:0] dev  = (rem_q >= HALF) ? (`PPSTS_CLK_HZ - rem_q) : rem_q;
  wire        on_grid  = dev <= TOL && rsec != 32'h0;
  wire        good     = ref_edge && (~have_prev_q || on_grid);
  wire        bad_p    = ref_edge && have_prev_q && ~on_grid;

  // ***************************************************
  // Phase error in ns from the fraction at the pulse
  // ***************************************************
  wire signed [63:0] prod = $signed({32'h0, ts_q[31:0]}) *
                            $signed(`PPSTS_NS_PER_S);
  wire [31:0] ph_pos = prod[63:32];
  wire [31:0] ph_ns  = ts_q[31] ? (ph_pos - 32'h3B9A_CA00) : ph_pos;
  wire [31:0] ph_abs = absval(ph_ns);
  wire [31:0] fr_ns  = ph_ns - phase_q;
  wire [31:0] sdiff  = ts_q[63:32] - host_sec_q;
  wire        far    = absval(sdiff) > 32'h0000_0001;

  // ***************************************************
  // Timestamp counter, 28 fraction bits kept
  // ***************************************************
  wire [91:0] step = {ts_q[63:4], sub_q} + {56'h0, `PPSTS_INC} +
                     {{76{trim_q[15]}}, trim_q};
  assign sec_wrap = step[91:60] != ts_q[63:32];

  // One contiguous count, no split carry between halves
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ts_q       <= 64'h0;
      sub_q      <= 32'h0;
      sec_tick_q <= 1'b0;
    end
    else if (do_set || (good && far))
    begin
      ts_q       <= {host_sec_q, host_frac_q[31:4], 4'h0};
      sub_q      <= 32'h0;
      sec_tick_q <= 1'b0;
    end
    else if (good && ~synced)
    begin
      // Step the fraction to the pulse for fast acquisition
      ts_q       <= {ts_q[63:32] + {31'h0, ts_q[31]}, 32'h0};
      sub_q      <= 32'h0;
      sec_tick_q <= 1'b0;
    end
    else
    begin
      ts_q       <= {step[91:32], 4'h0};
      sub_q      <= step[31:0];
      sec_tick_q <= sec_wrap;
    end
  end

  // ***************************************************
  // Discipline, sync state and statistics
  // ***************************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trim_q      <= 16'h0;
      synced      <= 1'b0;
      over_q      <= 8'h0;
      unsync_q    <= 8'h0;
      phase_q     <= 32'h0;
      freq_q      <= 32'h0;
      wfreq_q     <= 32'h0;
      wphase_q    <= 32'h0;
      fails_q     <= 32'h0;
      resync_q    <= 32'h0;
      total_q     <= 32'h0;
      bad_q       <= 32'h0;
      miss1_q     <= 32'h0;
      longest_q   <= 32'h0;
      last_q      <= 64'h0;
      ever_q      <= 1'b0;
      xtal_q      <= 32'h0;
      rem_q       <= 32'h0;
      gap_q       <= 32'h0;
      have_prev_q <= 1'b0;
    end
    else if (clr_st)
    begin
      // Clear, set, reset and reload clear the statistics but not last_q or xtal_q
      synced      <= 1'b0;
      over_q      <= 8'h0;
      unsync_q    <= 8'h0;
      phase_q     <= 32'h0;
      freq_q      <= 32'h0;
      wfreq_q     <= 32'h0;
      wphase_q    <= 32'h0;
      fails_q     <= 32'h0;
      resync_q    <= 32'h0;
      total_q     <= 32'h0;
      bad_q       <= 32'h0;
      miss1_q     <= 32'h0;
      longest_q   <= 32'h0;
      rem_q       <= 32'h0;
      gap_q       <= 32'h0;
      have_prev_q <= 1'b0;
    end
    else
    begin
      // Whole seconds and remainder since last good pulse
      if (good)
      begin
        rem_q <= 32'h0;
        gap_q <= 32'h0;
      end
      else if (rem_q == `PPSTS_CLK_HZ - 32'h0000_0001)
      begin
        rem_q <= 32'h0;
        gap_q <= gap_q + 32'h0000_0001;
      end
      else
        rem_q <= rem_q + 32'h0000_0001;

      if (ref_edge)
        total_q <= total_q + 32'h0000_0001;
      if (bad_p)
        bad_q <= bad_q + 32'h0000_0001;

      // Seconds without sync, only with a source chosen
      if (synced || in_sel_q == `PPSTS_IN_NONE)
        unsync_q <= 8'h0;
      else if (sec_tick_q && unsync_q != 8'hFF)
        unsync_q <= unsync_q + 8'h01;

      if (good)
      begin
        have_prev_q <= 1'b1;
        phase_q     <= ph_ns;
        last_q      <= ts_q;
        ever_q      <= 1'b1;
        if (far)
          resync_q <= resync_q + 32'h0000_0001;
        if (ph_abs > wphase_q)
          wphase_q <= ph_abs;
        if (have_prev_q)
        begin
          if (rsec == 32'h0000_0002)
            miss1_q <= miss1_q + 32'h0000_0001;
          if (rsec > longest_q)
            longest_q <= rsec;
          if (rsec == 32'h0000_0001)
          begin
            xtal_q <= `PPSTS_CLK_HZ + rem_q - dev - dev
                      + (rem_q >= HALF ? 32'h0 : dev + dev);
            freq_q <= fr_ns;
            if (absval(fr_ns) > wfreq_q)
              wfreq_q <= absval(fr_ns);
          end
        end
        // Nudge rate against the phase sign
        if (synced && ph_ns != 32'h0)
          trim_q <= trim_q + (ph_ns[31] ? 16'h0001 : 16'hFFFF);
        // Threshold test per accepted second
        if (ph_abs <= thresh_q)
        begin
          over_q <= 8'h0;
          synced <= 1'b1;
        end
        else if (synced)
        begin
          if (over_q == `PPSTS_LOSS_SECS - 8'h01)
          begin
            synced  <= 1'b0;
            over_q  <= 8'h0;
            fails_q <= fails_q + 32'h0000_0001;
          end
          else
            over_q <= over_q + 8'h01;
        end
      end
    end
  end

  // ***************************************************
  // Software registers and Avalon slave, one wait cycle
  // ***************************************************
  reg [31:0] rd_d;

  always @*
  begin
    case (avs_address)
      `PPSTS_A_CTRL:      rd_d = {26'h0, out_sel_q, in_sel_q};
      `PPSTS_A_THRESH:    rd_d = thresh_q;
      `PPSTS_A_HOST_SEC:  rd_d = host_sec_q;
      `PPSTS_A_HOST_FRAC: rd_d = host_frac_q;
      `PPSTS_A_TS_LO:     rd_d = ts_q[31:0];
      `PPSTS_A_TS_HI:     rd_d = ts_hi_snap_q;
      `PPSTS_A_STATUS:    rd_d = {30'h0, ~ever_q, synced};
      `PPSTS_A_PHASE:     rd_d = phase_q;
      `PPSTS_A_FREQ:      rd_d = freq_q;
      `PPSTS_A_WFREQ:     rd_d = wfreq_q;
      `PPSTS_A_WPHASE:    rd_d = wphase_q;
      `PPSTS_A_FAILS:     rd_d = fails_q;
      `PPSTS_A_RESYNC:    rd_d = resync_q;
      `PPSTS_A_TOTAL:     rd_d = total_q;
      `PPSTS_A_BAD:       rd_d = bad_q;
      `PPSTS_A_MISS1:     rd_d = miss1_q;
      `PPSTS_A_LONGEST:   rd_d = longest_q;
      `PPSTS_A_LAST_LO:   rd_d = last_q[31:0];
      `PPSTS_A_LAST_HI:   rd_d = last_q[63:32];
      `PPSTS_A_XTAL:      rd_d = xtal_q;
      `PPSTS_A_SYNTH:     rd_d = `PPSTS_SYNTH_HZ;
      default:            rd_d = 32'h0;
    endcase
  end

  // Each request stalls one cycle, then completes
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      in_sel_q        <= `PPSTS_IN_PORT;
      out_sel_q       <= `PPSTS_OUT_NONE;
      thresh_q        <= `PPSTS_THRESH_RST;
      host_sec_q      <= 32'h0;
      host_frac_q     <= 32'h0;
      ts_hi_snap_q    <= 32'h0;
    end
    else
    begin
      avs_waitrequest <= ~((avs_read || avs_write) && avs_waitrequest);
      if ((avs_read || avs_write) && avs_waitrequest)
        avs_readdata <= rd_d;
      // Low word read freezes the high word at the same edge, so a
      // fraction wrap between the two captures cannot split the pair
      if (avs_read && avs_waitrequest && avs_address == `PPSTS_A_TS_LO)
        ts_hi_snap_q <= ts_q[63:32];
      if (wr && avs_address == `PPSTS_A_CTRL)
      begin
        if (avs_byteenable[0])
        begin
          in_sel_q  <= avs_writedata[2:0];
          out_sel_q <= avs_writedata[5:3];
        end
      end
      if (wr && avs_address == `PPSTS_A_THRESH)
        thresh_q <= be_merge(thresh_q, avs_writedata,
                             avs_byteenable);
      if (wr && avs_address == `PPSTS_A_HOST_SEC)
        host_sec_q <= be_merge(host_sec_q, avs_writedata,
                               avs_byteenable);
      if (wr && avs_address == `PPSTS_A_HOST_FRAC)
        host_frac_q <= be_merge(host_frac_q, avs_writedata,
                                avs_byteenable);
      if (cmd_wr && cmd[`PPSTS_CMD_NONE])
      begin
        in_sel_q  <= `PPSTS_IN_NONE;
        out_sel_q <= `PPSTS_OUT_NONE;
      end
      if (do_rst || (cmd_wr && cmd[`PPSTS_CMD_DEF]))
      begin
        in_sel_q  <= `PPSTS_IN_PORT;
        out_sel_q <= `PPSTS_OUT_NONE;
        thresh_q  <= `PPSTS_THRESH_RST;
      end
    end
  end

  // ***************************************************
  // Output pulse and status outputs
  // ***************************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse_out <= 1'b0;
      ts_out    <= 64'h0;
    end
    else
    begin
      ts_out <= ts_q;
      case (out_sel_q)
        `PPSTS_OUT_REP:  pulse_out <= sy2_q;
        `PPSTS_OUT_LOOP: pulse_out <= (in_sel_q == `PPSTS_IN_OVER) ?
                                      ~ts_q[31] :
                                      (in_sel_q == `PPSTS_IN_PORT) &
                                      sy2_q;
        // Master pulse is high for the first half second
        `PPSTS_OUT_OVER: pulse_out <= ~ts_q[31];
        default:         pulse_out <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### ppsts_unused_note_placeholder_removed.v
// Empty companion source; all design logic lives in the clock module
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### ppsts_pulse_src.sv
// Reference pulse source standing in for the receiver or peer card
`timescale 1ns/1ps
`default_nettype none

module ppsts_pulse_src
(
  input  wire logic core_clk, // Card clock
  input  wire logic rst_n,    // Async reset, active low
  input  wire logic fire,     // One-cycle request for a pulse
  output wire logic pulse     // Reference pulse, active high
);
  logic [2:0] cnt_q;

  // Four cycles high so the two-flop synchroniser cannot miss it
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      cnt_q <= 3'h0;
    else if (fire)
      cnt_q <= 3'h4;
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;

  // Line idles low between pulses, like a driven receiver output
  assign pulse = (cnt_q != 3'h0);
endmodule

`default_nettype wire

// ### ppsts_clock_monitor.sv
// Bus, timestamp and pulse-output checker for the timestamp clock
`timescale 1ns/1ps
`default_nettype none
`include "ppsts_consts.vh"

module ppsts_clock_monitor
(
  input wire logic        core_clk,         // 200 MHz clock
  input wire logic        rst_n,            // Async reset, active low
  input wire logic [7:0]  avs_address,      // Byte address
  input wire logic        avs_read,         // Read request
  input wire logic        avs_write,        // Write request
  input wire logic [31:0] avs_writedata,    // Write data
  input wire logic [3:0]  avs_byteenable,   // Byte lanes
  input wire logic [31:0] avs_readdata,     // Read data
  input wire logic        avs_waitrequest,  // Stall
  input wire logic        pulse_port_input, // Reference pulse
  input wire logic        aux_pulse_in,     // Auxiliary pulse
  input wire logic        pulse_out,        // Outgoing pulse
  input wire logic [63:0] ts_out,           // Live timestamp
  input wire logic        synced            // Synchronised flag
);
  // ***************************************************
  // Helper state
  // ***************************************************
  logic [2:0] out_q;
  logic [3:0] quiet_q;
  logic       wr_done;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  assign wr_done = avs_write && !avs_waitrequest;

  // Shadow of the output selector; deselecting commands force none
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      out_q <= 3'h0;
    else if (wr_done && avs_address == `PPSTS_A_CTRL)
      out_q <= avs_writedata[5:3];
    else if (wr_done && avs_address == `PPSTS_A_CMD && |avs_writedata[4:2])
      out_q <= 3'h0;

  // Cycles since a write or pulse, which may legally step the time
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      quiet_q <= 4'h0;
    else if (avs_write || pulse_port_input)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hF)
      quiet_q <= quiet_q + 4'h1;

  // ***************************************************
  // Assertions
  // ***************************************************
  property p_ts_low;
    ts_out[3:0] == 4'h0;
  endproperty
  a_ts_low: assert property (p_ts_low)
    else $error("timestamp low bits not zero");

  // Two cycles apart: a pulse may step the time onto the second it shows
  property p_ts_moves;
    $past(rst_n) && $past(rst_n, 2) |-> ts_out != $past(ts_out, 2);
  endproperty
  a_ts_moves: assert property (p_ts_moves)
    else $error("timestamp did not advance");

  property p_sec_carry;
    quiet_q > 4'h8 && $past(ts_out[31]) && !ts_out[31]
      |-> ts_out[63:32] == $past(ts_out[63:32]) + 32'h1;
  endproperty
  a_sec_carry: assert property (p_sec_carry)
    else $error("fraction wrap did not carry into seconds");

  property p_taken;
    (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_taken: assert property (p_taken)
    else $error("bus request not answered");

  property p_ack_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("waitrequest low longer than one cycle");

  property p_ack_req;
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("answer without request");

  property p_unmapped;
    avs_read && !avs_waitrequest
      && (avs_address > `PPSTS_A_SYNTH || avs_address == `PPSTS_A_CMD)
      |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped or command read not zero");

  property p_out_none;
    $past(out_q) == 3'h0 && $past(out_q, 2) == 3'h0 |-> !pulse_out;
  endproperty
  a_out_none: assert property (p_out_none)
    else $error("pulse output active with no source");

  property p_out_rep;
    $rose(pulse_port_input) && out_q == 3'h1 |-> ##[1:5] pulse_out;
  endproperty
  a_out_rep: assert property (p_out_rep)
    else $error("port pulse not repeated");
endmodule

bind ppsts_clock ppsts_clock_monitor i_mon
(
  .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pulse_port_input(pulse_port_input), .aux_pulse_in(aux_pulse_in),
  .pulse_out(pulse_out), .ts_out(ts_out), .synced(synced)
);

`default_nettype wire

// ### test_pps_timestamp_clock_sync.sv
// Self-checking bench for the pulse-disciplined timestamp clock
`timescale 1ns/1ps
`default_nettype none
`include "ppsts_consts.vh"

module test_pps_timestamp_clock_sync;
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pulse_port_input;
  logic        pulse_out;
  logic [63:0] ts_out;
  logic        synced;
  logic        fire;
  int          err_count;
  int          total_checks;

  // Byte lanes all on; auxiliary input is unused by the block
  ppsts_clock i_dut
  (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pulse_port_input(pulse_port_input), .aux_pulse_in(1'b0),
    .pulse_out(pulse_out), .ts_out(ts_out), .synced(synced)
  );

  ppsts_pulse_src i_src
  (
    .core_clk(core_clk), .rst_n(rst_n), .fire(fire),
    .pulse(pulse_port_input)
  );

  // ***************************************************
  // Clock, verdict and bus tasks
  // ***************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic stop_test;
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  // Request held until waitrequest is sampled low; watchdog ends a hang
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // One reference pulse; reports whether the output pulse showed up
  task automatic pulse_once(output logic seen);
    seen = 1'b0;
    @(posedge core_clk);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    repeat (12)
    begin
      @(posedge core_clk);
      seen = seen | (pulse_out === 1'b1);
    end
  endtask

  // ***************************************************
  // Scenarios
  // ***************************************************
  task automatic t_reset;
    rd(`PPSTS_A_CTRL, 32'h0000_0001);
    rd(`PPSTS_A_THRESH, 32'h0000_0254);
    rd(`PPSTS_A_STATUS, 32'h0000_0002);
    rd(`PPSTS_A_SYNTH, 32'h1000_0000);
    rd(`PPSTS_A_TOTAL, 32'h0000_0000);
    rd(8'h58, 32'h0000_0000);
    rd(`PPSTS_A_CMD, 32'h0000_0000);
  endtask

  // Repeat and loop outputs, then deselect and defaults
  task automatic t_select;
    logic       s;
    logic [2:0] k;
    for (k = 3'h1; k <= 3'h2; k++)
    begin
      wr(`PPSTS_A_CTRL, {26'h0, k, 3'h1});
      pulse_once(s);
      chk(s, 1'b1);
    end
    chk(synced, 1'b1);
    rd(`PPSTS_A_STATUS, 32'h0000_0001);
    rd(`PPSTS_A_TOTAL, 32'h0000_0002);
    rd(`PPSTS_A_BAD, 32'h0000_0001);
    rd(`PPSTS_A_MISS1, 32'h0000_0000);
    wr(`PPSTS_A_CMD, 32'h0000_0010);
    rd(`PPSTS_A_CTRL, 32'h0000_0000);
    pulse_once(s);
    chk(s, 1'b0);
    rd(`PPSTS_A_TOTAL, 32'h0000_0002);
    wr(`PPSTS_A_CMD, 32'h0000_0008);
    rd(`PPSTS_A_CTRL, 32'h0000_0001);
  endtask

  // Every statistic from worst frequency to longest gap reads zero
  task automatic t_clear;
    logic [7:0] a;
    wr(`PPSTS_A_CMD, 32'h0000_0001);
    for (a = `PPSTS_A_WFREQ; a <= `PPSTS_A_LONGEST; a = a + 8'h04)
      rd(a, 32'h0000_0000);
    chk(synced, 1'b0);
  endtask

  task automatic t_set;
    logic [31:0] q;
    logic        s;
    wr(`PPSTS_A_HOST_SEC, 32'h1234_5678);
    wr(`PPSTS_A_HOST_FRAC, 32'h1000_0000);
    wr(`PPSTS_A_CMD, 32'h0000_0002);
    bus(1'b0, `PPSTS_A_TS_LO, 32'h0000_0000, q);
    chk(q & 32'hF000_000F, 32'h1000_0000);
    rd(`PPSTS_A_TS_HI, 32'h1234_5678);
    pulse_once(s);
    rd(`PPSTS_A_TOTAL, 32'h0000_0001);
    rd(`PPSTS_A_LAST_HI, 32'h1234_5678);
    bus(1'b0, `PPSTS_A_STATUS, 32'h0000_0000, q);
    chk(q & 32'h0000_0002, 32'h0000_0000);
  endtask

  // Fraction close to wrapping: seconds carry, internal pulse counts
  task automatic t_over;
    logic [31:0] q;
    wr(`PPSTS_A_CTRL, 32'h0000_0023);
    wr(`PPSTS_A_HOST_SEC, 32'h0000_00FF);
    wr(`PPSTS_A_HOST_FRAC, 32'hFFFF_F000);
    wr(`PPSTS_A_CMD, 32'h0000_0002);
    repeat (400) @(posedge core_clk);
    bus(1'b0, `PPSTS_A_TS_LO, 32'h0000_0000, q);
    rd(`PPSTS_A_TS_HI, 32'h0000_0100);
    chk(pulse_out, 1'b1);
    rd(`PPSTS_A_TOTAL, 32'h0000_0001);
  endtask

  task automatic t_full;
    logic [31:0] q;
    wr(`PPSTS_A_HOST_FRAC, 32'h0000_0000);
    wr(`PPSTS_A_THRESH, 32'h0000_0064);
    rd(`PPSTS_A_THRESH, 32'h0000_0064);
    wr(`PPSTS_A_CMD, 32'h0000_0004);
    bus(1'b0, `PPSTS_A_TS_LO, 32'h0000_0000, q);
    rd(`PPSTS_A_TS_HI, 32'h0000_00FF);
    rd(`PPSTS_A_CTRL, 32'h0000_0001);
    rd(`PPSTS_A_THRESH, 32'h0000_0254);
    rd(`PPSTS_A_TOTAL, 32'h0000_0000);
    chk(pulse_out, 1'b0);
  endtask

  // Main sequence: two cycles of reset, then the scenarios
  initial
  begin
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    fire = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_select();
    t_clear();
    t_set();
    t_over();
    t_full();
    stop_test();
  end

  // Watchdog, well past the several hundred cycles the run needs
  initial
  begin
    #100000;
    err_count++;
    stop_test();
  end
endmodule

`default_nettype wire
